// *** core/ufp_fifo_port.sv ***
// Byte-wide strobe FIFO port with AHB-Lite register access
`timescale 1ns/1ns
module ufp_fifo_port import ufp_pkg::*; #(
	parameter int RxDepth = 16,
	parameter int TxDepth = 16,
	parameter int unsigned WakeCycles = UFP_WAKE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire ufp_pin_in_t pinIn,
	output ufp_pin_out_t pinOut
);

	localparam int RxAw = $clog2(RxDepth);
	localparam int TxAw = $clog2(TxDepth);
	localparam int RxCw = RxAw + 1;
	localparam int TxCw = TxAw + 1;
	localparam logic [RxCw-1:0] RxFull = RxCw'(RxDepth);
	localparam logic [TxCw-1:0] TxFull = TxCw'(TxDepth);

	typedef struct packed {
		logic [2:0] rdS;
		logic [2:0] wrS;
		logic [1:0] rxPinS;
		logic [1:0][7:0] dS;
		ufp_ctrl_t ctrl;
		logic wakeReq;
		logic rxOvf;
		logic [31:0] wakeCnt;
		logic [RxDepth-1:0][7:0] rxMem;
		logic [RxAw-1:0] rxWr;
		logic [RxAw-1:0] rxRd;
		logic [RxCw-1:0] rxCount;
		logic [TxDepth-1:0][7:0] txMem;
		logic [TxAw-1:0] txWr;
		logic [TxAw-1:0] txRd;
		logic [TxCw-1:0] txCount;
		logic wrPend;
		logic [11:0] addrPend;
		logic [31:0] rdata;
		logic readyOut;
		ufp_pin_out_t pins;
	} ufp_state_t;

	logic [1:0] rstSync;
	logic rstN;
	ufp_state_t st;
	ufp_state_t nx;
	logic rdFall;
	logic wrFall;
	logic addrTaken;
	logic rxPush;
	logic txPop;
	logic wakeMode;

	function automatic logic fellEdge(input logic [2:0] s);
		fellEdge = s[2] & ~s[1];
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	assign rdFall = fellEdge(st.rdS);
	assign wrFall = fellEdge(st.wrS);
	assign addrTaken = hsel && hready && (htrans == UFP_HTRANS_NONSEQ || htrans == 2'h3);
	assign rxPush = st.wrPend && st.addrPend == UFP_RXDATA_OFS;
	assign txPop = addrTaken && !hwrite && haddr[11:0] == UFP_TXDATA_OFS && st.txCount != '0;
	assign wakeMode = st.ctrl.remoteWakeOpt && st.pins.powerEnableN;

	always_comb begin
		logic rxPop;
		logic txPush;
		logic [31:0] rd;
		nx = st;
		rxPop = 1'b0;
		txPush = 1'b0;
		rd = 32'h0;

		// Pin synchronisers; first stage feeds only the second
		nx.rdS = {st.rdS[1:0], pinIn.readStrobeN};
		nx.wrS = {st.wrS[1:0], pinIn.writeStrobe};
		nx.rxPinS = {st.rxPinS[0], pinIn.rxAvailN};
		nx.dS = {st.dS[0], pinIn.data};

		// Read strobe falls: latch head byte and advance
		if (rdFall && st.rxCount != '0) begin
			nx.pins.data = st.rxMem[st.rxRd];
			nx.rxRd = RxAw'(st.rxRd + 1'b1);
			rxPop = 1'b1;
		end

		// Write strobe falls: capture bus byte when room
		if (wrFall && st.txCount != TxFull) begin
			nx.txMem[st.txWr] = st.dS[1];
			nx.txWr = TxAw'(st.txWr + 1'b1);
			txPush = 1'b1;
		end

		// AHB data phase of a write
		if (st.wrPend) begin
			unique case (st.addrPend)
				UFP_CTRL_OFS: begin
					nx.ctrl = ufp_ctrl_t'(hwdata[3:0]);
				end
				UFP_STATUS_OFS: begin
					if (hwdata[UFP_ST_WAKE]) begin
						nx.wakeReq = 1'b0;
					end
					if (hwdata[UFP_ST_RX_OVF]) begin
						nx.rxOvf = 1'b0;
					end
				end
				UFP_RXDATA_OFS: begin
					if (st.rxCount != RxFull) begin
						nx.rxMem[st.rxWr] = hwdata[7:0];
						nx.rxWr = RxAw'(st.rxWr + 1'b1);
					end
				end
				default: begin
				end
			endcase
		end
		if (rxPush && st.rxCount == RxFull) begin
			nx.rxOvf = 1'b1;
		end

		nx.rxCount = RxCw'(st.rxCount + RxCw'(rxPush && st.rxCount != RxFull) - RxCw'(rxPop));
		nx.txCount = TxCw'(st.txCount + TxCw'(txPush) - TxCw'(txPop));
		if (txPop) begin
			nx.txRd = TxAw'(st.txRd + 1'b1);
		end

		// AHB address phase; read data prepared for the data phase
		nx.wrPend = addrTaken && hwrite;
		if (addrTaken) begin
			nx.addrPend = haddr[11:0];
		end
		if (addrTaken && !hwrite) begin
			unique case (haddr[11:0])
				UFP_CTRL_OFS: begin
					rd[3:0] = st.ctrl;
				end
				UFP_STATUS_OFS: begin
					rd[UFP_ST_RX_AVAIL] = st.rxCount != '0;
					rd[UFP_ST_TX_SPACE] = st.txCount != TxFull;
					rd[UFP_ST_WAKE] = st.wakeReq;
					rd[UFP_ST_RX_OVF] = st.rxOvf;
					rd[UFP_ST_RX_COUNT +: 8] = 8'(st.rxCount);
					rd[UFP_ST_TX_COUNT +: 8] = 8'(st.txCount);
				end
				UFP_TXDATA_OFS: begin
					if (st.txCount != '0) begin
						rd[7:0] = st.txMem[st.txRd];
						rd[UFP_TXDATA_VALID] = 1'b1;
					end
				end
				default: begin
				end
			endcase
			nx.rdata = rd;
		end
		nx.readyOut = 1'b1;

		// Remote wakeup: count low time on the receive flag pin
		if (wakeMode && !st.rxPinS[1]) begin
			if (st.wakeCnt >= 32'(WakeCycles - 1)) begin
				nx.wakeReq = 1'b1;
			end else begin
				nx.wakeCnt = st.wakeCnt + 32'h1;
			end
		end else begin
			nx.wakeCnt = 32'h0;
		end

		// Pins
		nx.pins.dataOe = !st.rdS[1];
		nx.pins.txSpaceN = nx.txCount == TxFull;
		nx.pins.txSpaceOe = 1'b1;
		nx.pins.rxAvailN = nx.rxCount == '0;
		nx.pins.powerEnableN = !(nx.ctrl.configured && !nx.ctrl.suspended);
		nx.pins.rxAvailOe = !(nx.ctrl.remoteWakeOpt && nx.pins.powerEnableN);
		nx.pins.weakPullLow = nx.ctrl.pullLowOpt && nx.pins.powerEnableN;
		nx.pins.resumeRequest = nx.wakeReq;
	end

	// Whole state; reset floats both flags and the data bus
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			st <= '0;
			st.rdS <= 3'h7;
			st.rxPinS <= 2'h3;
			st.ctrl <= UFP_CTRL_RESET;
			st.pins.txSpaceN <= 1'b1;
			st.pins.rxAvailN <= 1'b1;
			st.pins.powerEnableN <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	assign hreadyout = st.readyOut;
	assign hresp = UFP_HRESP_OKAY;
	assign hrdata = st.rdata;
	assign pinOut = st.pins;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstN);

	logic [31:0] lowRun;
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			lowRun <= 32'h0;
		end else if (wakeMode && !st.rxPinS[1]) begin
			lowRun <= lowRun + 32'h1;
		end else begin
			lowRun <= 32'h0;
		end
	end

	power_enable_a: assert property (st.ctrl.configured && !st.ctrl.suspended
		|-> !pinOut.powerEnableN)
		else $error("power enable not low when configured");
	suspend_power_a: assert property (st.ctrl.suspended |-> pinOut.powerEnableN)
		else $error("power enable not high in suspend");
	data_drive_a: assert property (st.rdS[1] && st.rdS[2] |=> !pinOut.dataOe)
		else $error("data bus driven while read strobe high");
	rx_pop_a: assert property (rdFall && st.rxCount != '0 && !rxPush
		|=> st.rxCount == $past(st.rxCount) - 1'b1 && pinOut.data == $past(st.rxMem[st.rxRd]))
		else $error("read strobe did not fetch byte");
	rx_empty_hold_a: assert property (rdFall && st.rxCount == '0 && !rxPush
		|=> st.rxCount == '0 && $stable(st.rxRd))
		else $error("empty receive buffer advanced");
	tx_capture_a: assert property (wrFall && st.txCount != TxFull && !txPop
		|=> st.txCount == $past(st.txCount) + 1'b1 && st.txMem[$past(st.txWr)] == $past(st.dS[1]))
		else $error("write strobe byte not captured");
	tx_full_flag_a: assert property (st.txCount == TxFull |-> pinOut.txSpaceN)
		else $error("space flag low while full");
	rx_flag_a: assert property (!pinOut.rxAvailN |-> st.rxCount != '0)
		else $error("receive flag low while empty");
	reset_float_a: assert property (disable iff (1'b0) !rstN
		|-> !pinOut.txSpaceOe && !pinOut.rxAvailOe && !pinOut.dataOe)
		else $error("status flags driven in reset");
	wake_input_a: assert property (st.ctrl.remoteWakeOpt && pinOut.powerEnableN
		&& $stable(st.ctrl) |-> !pinOut.rxAvailOe)
		else $error("receive flag pin not released in wakeup mode");
	wake_time_a: assert property (wakeMode && !st.rxPinS[1]
		&& lowRun == 32'(WakeCycles - 1) |=> st.wakeReq && pinOut.resumeRequest)
		else $error("resume request missing after low time");
	wake_early_a: assert property ($rose(st.wakeReq) |-> $past(lowRun) >= 32'(WakeCycles - 1))
		else $error("resume request too early");
	pull_low_a: assert property (pinOut.weakPullLow |-> st.ctrl.pullLowOpt && pinOut.powerEnableN)
		else $error("weak pull low outside suspend option");
	strobe_once_a: assert property (rdFall |=> ##1 $stable(st.rxRd) [*2])
		else $error("read strobe edge acted twice");
	write_once_a: assert property (wrFall |=> ##1 $stable(st.txWr) [*2])
		else $error("write strobe edge acted twice");
	data_enable_a: assert property (!st.rdS[1] |=> pinOut.dataOe)
		else $error("data bus not driven while read strobe low");
	tx_refuse_a: assert property (wrFall && st.txCount == TxFull && !txPop
		|=> st.txCount == $past(st.txCount))
		else $error("write accepted while transmit buffer full");

	rx_pop_c: cover property (rdFall && st.rxCount != '0);
	tx_push_c: cover property (wrFall && st.txCount != TxFull);
	tx_full_c: cover property (st.txCount == TxFull);
	wake_req_c: cover property ($rose(st.wakeReq));
	rx_empty_c: cover property (rdFall && st.rxCount == '0);

endmodule

// *** shared/ufp_pkg.sv ***
// Constants and carrier types for the byte-wide strobe FIFO port
// How it works
// - Power enable goes low once configured, high again while suspended.
// - Receive byte is driven on the data bus only while read strobe is low.
// - Read strobe falling edge fetches the next receive byte; empty buffer never advances.
// - Write strobe falling edge captures the data bus byte into the transmit buffer.
// - Transmit space flag stays high while transmit buffer is full; writes only when low.
// - Receive available flag is low only while the receive buffer holds a byte.
// - Both status flags float while the device is held in reset.
// - Remote wakeup enabled and suspended turns the receive flag pin into an input.
// - Receive flag pin held low 20 ms during suspend raises a resume request.
// - Suspend pull-low option pulls input pins low while suspended, else high.
package ufp_pkg;

	// Register byte offsets
	localparam logic [11:0] UFP_CTRL_OFS = 12'h000;
	localparam logic [11:0] UFP_STATUS_OFS = 12'h004;
	localparam logic [11:0] UFP_RXDATA_OFS = 12'h008;
	localparam logic [11:0] UFP_TXDATA_OFS = 12'h00c;

	// Control fields
	localparam int UFP_CTRL_CONFIGURED = 0;
	localparam int UFP_CTRL_SUSPENDED = 1;
	localparam int UFP_CTRL_REMOTE_WAKE = 2;
	localparam int UFP_CTRL_PULL_LOW = 3;
	localparam logic [3:0] UFP_CTRL_RESET = 4'h0;

	// Status fields
	localparam int UFP_ST_RX_AVAIL = 0;
	localparam int UFP_ST_TX_SPACE = 1;
	localparam int UFP_ST_WAKE = 2;
	localparam int UFP_ST_RX_OVF = 3;
	localparam int UFP_ST_RX_COUNT = 8;
	localparam int UFP_ST_TX_COUNT = 16;
	localparam int UFP_TXDATA_VALID = 8;

	// AHB-Lite codes
	localparam logic [1:0] UFP_HTRANS_NONSEQ = 2'h2;
	localparam logic UFP_HRESP_OKAY = 1'b0;

	// Remote wakeup low time
	localparam int unsigned UFP_WAKE_TIME_US = 20000;
	localparam int unsigned UFP_CLK_PERIOD_NS = 100;
	localparam int unsigned UFP_WAKE_CYCLES = UFP_WAKE_TIME_US * 1000 / UFP_CLK_PERIOD_NS;

	typedef struct packed {
		logic pullLowOpt;
		logic remoteWakeOpt;
		logic suspended;
		logic configured;
	} ufp_ctrl_t;

	typedef struct packed {
		logic [7:0] data;
		logic readStrobeN;
		logic writeStrobe;
		logic rxAvailN;
	} ufp_pin_in_t;

	typedef struct packed {
		logic [7:0] data;
		logic dataOe;
		logic txSpaceN;
		logic txSpaceOe;
		logic rxAvailN;
		logic rxAvailOe;
		logic powerEnableN;
		logic weakPullLow;
		logic resumeRequest;
	} ufp_pin_out_t;

endpackage

// *** sim/ufp_ext_model.sv ***
// External logic model on the strobe FIFO pins
`timescale 1ns/1ns
module ufp_ext_model import ufp_pkg::*; (
	input wire logic clk_sys,
	input wire ufp_pin_out_t pinOut,
	output ufp_pin_in_t pinIn
);
	logic [7:0] busDrive;
	logic busOe;
	logic wakeLow;
	logic readStrobeN;
	logic writeStrobe;
	// Undriven bus follows the weak pull
	assign pinIn.data = pinOut.dataOe ? pinOut.data : busOe ? busDrive :
		pinOut.weakPullLow ? 8'h00 : 8'hff;
	// Pulled up unless the model pulls it low
	assign pinIn.rxAvailN = pinOut.rxAvailOe ? pinOut.rxAvailN : !wakeLow;
	assign pinIn.readStrobeN = readStrobeN;
	assign pinIn.writeStrobe = writeStrobe;
	initial begin
		busDrive = 8'h00;
		busOe = 1'b0;
		wakeLow = 1'b0;
		readStrobeN = 1'b1;
		writeStrobe = 1'b0;
	end
	task automatic waitCycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask
	task automatic readByte(output logic [7:0] b);
		readStrobeN <= 1'b0;
		waitCycles(6);
		@(negedge clk_sys);
		b = pinIn.data;
		@(posedge clk_sys);
		readStrobeN <= 1'b1;
		waitCycles(6);
	endtask
	task automatic writeByte(input logic [7:0] b);
		busDrive <= b;
		busOe <= 1'b1;
		writeStrobe <= 1'b1;
		waitCycles(6);
		writeStrobe <= 1'b0;
		waitCycles(6);
		busOe <= 1'b0;
		waitCycles(2);
	endtask
	task automatic wake(input int n);
		wakeLow <= 1'b1;
		waitCycles(n);
		wakeLow <= 1'b0;
		waitCycles(4);
	endtask
endmodule

// *** sim/ufp_fifo_port_tb.sv ***
// Self-checking testbench for the strobe FIFO port
`timescale 1ns/1ns
module ufp_fifo_port_tb import ufp_pkg::*;;
	localparam int WAKE = 50;
	localparam int TXD = 4;
	logic clk_sys, resetn, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [7:0] b;
	ufp_pin_in_t pinIn;
	ufp_pin_out_t pinOut;
	int nMismatch = 0;
	int testsRun = 0;
	ufp_fifo_port #(.RxDepth(4), .TxDepth(TXD), .WakeCycles(WAKE)) dut_u (
		.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pinIn(pinIn), .pinOut(pinOut));
	ufp_ext_model ext_u (.clk_sys(clk_sys), .pinOut(pinOut), .pinIn(pinIn));
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			nMismatch++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		htrans <= UFP_HTRANS_NONSEQ;
		hwrite <= wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic ctrl(input logic [31:0] v);
		ahb(1'b1, UFP_CTRL_OFS, v);
		repeat (3) @(posedge clk_sys);
	endtask
	task automatic testReset();
		check({pinOut.txSpaceOe, pinOut.rxAvailOe, pinOut.dataOe}, 32'h0);
		check(pinOut.powerEnableN, 32'h1);
	endtask
	task automatic testPower();
		ctrl(32'h1);
		check(pinOut.powerEnableN, 32'h0);
		ctrl(32'h3);
		check(pinOut.powerEnableN, 32'h1);
		ctrl(32'h1);
	endtask
	task automatic testRx();
		ahb(1'b1, UFP_RXDATA_OFS, 32'ha5);
		ahb(1'b1, UFP_RXDATA_OFS, 32'h3c);
		repeat (3) @(posedge clk_sys);
		check(pinOut.rxAvailN, 32'h0);
		ext_u.readByte(b);
		check(b, 32'ha5);
		check(pinOut.dataOe, 32'h0);
		ahb(1'b0, UFP_STATUS_OFS, 32'h0);
		check(rd[15:8], 32'h1);
		ext_u.readByte(b);
		check(b, 32'h3c);
		check(pinOut.rxAvailN, 32'h1);
		ext_u.readByte(b);
		check(b, 32'h3c);
		ahb(1'b0, UFP_STATUS_OFS, 32'h0);
		check(rd[15:8], 32'h0);
	endtask
	task automatic testTx();
		check(pinOut.txSpaceN, 32'h0);
		for (int i = 0; i < TXD; i++) begin
			ext_u.writeByte(8'h10 + 8'(i));
		end
		check(pinOut.txSpaceN, 32'h1);
		ext_u.writeByte(8'hee);
		for (int i = 0; i < TXD; i++) begin
			ahb(1'b0, UFP_TXDATA_OFS, 32'h0);
			check(rd, 32'h110 + 32'(i));
		end
		ahb(1'b0, UFP_TXDATA_OFS, 32'h0);
		check(rd, 32'h0);
		repeat (3) @(posedge clk_sys);
		check(pinOut.txSpaceN, 32'h0);
	endtask
	task automatic testWake();
		ctrl(32'hf);
		check({pinOut.rxAvailOe, pinOut.weakPullLow}, 32'h1);
		check(pinIn.data, 32'h0);
		ext_u.wake(WAKE / 2);
		check(pinOut.resumeRequest, 32'h0);
		ext_u.wake(WAKE + 10);
		check(pinOut.resumeRequest, 32'h1);
		ahb(1'b0, UFP_STATUS_OFS, 32'h0);
		check(rd[2], 32'h1);
		ahb(1'b1, UFP_STATUS_OFS, 32'h4);
		ctrl(32'h1);
		check({pinOut.rxAvailOe, pinOut.weakPullLow, pinOut.resumeRequest}, 32'h4);
		check(pinIn.data, 32'hff);
	endtask
	task automatic testMidReset();
		ahb(1'b1, UFP_RXDATA_OFS, 32'h5a);
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		check({pinOut.txSpaceOe, pinOut.rxAvailOe, pinOut.dataOe}, 32'h0);
		check(pinOut.powerEnableN, 32'h1);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		check(pinOut.rxAvailN, 32'h1);
		ahb(1'b0, UFP_STATUS_OFS, 32'h0);
		check(rd, 32'h1 << UFP_ST_TX_SPACE);
	endtask
	task automatic finish_test();
		$display("mismatches %0d comparisons %0d", nMismatch, testsRun);
		if (nMismatch == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		repeat (5) @(posedge clk_sys);
		testReset();
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		testPower();
		testRx();
		testTx();
		testWake();
		testMidReset();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		nMismatch++;
		finish_test();
	end
endmodule
